/* rtl/ccsb_pkg.sv */
// constants, reset values and state type for the clock synth config bank
// assumes one 10 MHz clock and pins already synchronous to it
// Behaviour
// - eight settings, index from three select pins
// - active index picks bits from config bytes
// - per-setting bits indexed by select combination
// - generic block at 00h, loop block 10h
// - bit 7 of 00h read-only variant
// - bits 6:4 of 00h read-only revision
// - bits 3:0 of 00h read-only vendor
// - lock bit 01h bit 5, reset zero
// - power down bit overrides pins for the loop and first output and kills them
// - power down never saved as one
// - 01h bits 1:0 are low address bits
// - 02h bit 7 picks first output source
// - 02h bit 6 picks shared pin function
// - two-bit output state decode table
// - stored pin choice removes serial pins
// - stored lock refuses saves, keeps writes
package ccsb_pkg;
    // geometry
    localparam int CFG_DEPTH = 32;
    localparam int IDX_W = 3;
    localparam int SPREAD_W = 3;
    // byte offsets
    localparam logic [4:0] OFF_IDENT = 5'h00;
    localparam logic [4:0] OFF_GENERAL = 5'h01;
    localparam logic [4:0] OFF_OUTSRC = 5'h02;
    localparam logic [4:0] OFF_FIRST_STATE = 5'h04;
    localparam logic [4:0] OFF_SAVE = 5'h06;
    localparam logic [4:0] OFF_LOOP_BASE = 5'h10;
    localparam logic [4:0] OFF_SPREAD_LO = 5'h10;
    localparam logic [4:0] OFF_SPREAD_MID = 5'h11;
    localparam logic [4:0] OFF_SPREAD_HI = 5'h12;
    localparam logic [4:0] OFF_FREQ = 5'h13;
    localparam logic [4:0] OFF_SECOND_THIRD = 5'h15;
    // general control byte fields
    localparam int GEN_RSVD = 7;
    localparam int GEN_BUSY = 6;
    localparam int GEN_LOCK = 5;
    localparam int GEN_PDN = 4;
    localparam int GEN_SRC_HI = 3;
    localparam int GEN_SRC_LO = 2;
    localparam int GEN_ADR_HI = 1;
    localparam int GEN_ADR_LO = 0;
    // output source / pin function byte fields
    localparam int OUT_SRC = 7;
    localparam int OUT_PINFN = 6;
    localparam int ST1_HI = 5;
    localparam int ST1_LO = 4;
    localparam int ST0_HI = 3;
    localparam int ST0_LO = 2;
    // save byte field
    localparam int SAVE_GO = 0;
    // reset values
    localparam logic [7:0] RST_GENERAL = 8'h01;
    localparam logic [7:0] RST_OUTSRC = 8'hB4;
    localparam logic [7:0] RST_FIRST_STATE = 8'h02;
    localparam logic [7:0] RST_SAVE = 8'h40;
    localparam logic [7:0] RST_OTHER = 8'h00;
    // codes
    localparam logic [1:0] SRC_RESERVED = 2'h3;
    localparam logic [1:0] ST_POWER_DOWN = 2'h0;
    localparam logic [1:0] ST_HIGH_Z = 2'h1;
    localparam logic [1:0] ST_DRIVE_LOW = 2'h2;
    localparam logic [1:0] ST_ENABLED = 2'h3;
    // nonvolatile save duration in clock cycles
    localparam logic [4:0] NV_SAVE_COUNT = 5'h10;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // serial engine states
    typedef enum logic [3:0] {
        SER_IDLE, SER_ADDR, SER_ADDR_ACK, SER_CMD, SER_CMD_ACK,
        SER_WDATA, SER_WDATA_ACK, SER_RDATA, SER_RDATA_ACK
    } ccsb_ser_state_e;

    // reset value of each stored byte
    function automatic logic [7:0] ccsb_reset_byte(input int idx);
        logic [7:0] v;
        v = RST_OTHER;
        if (idx == int'(OFF_GENERAL)) v = RST_GENERAL;
        else if (idx == int'(OFF_OUTSRC)) v = RST_OUTSRC;
        else if (idx == int'(OFF_FIRST_STATE)) v = RST_FIRST_STATE;
        else if (idx == int'(OFF_SAVE)) v = RST_SAVE;
        return v;
    endfunction
endpackage

/* rtl/ccsb_bit_pick.sv */
// picks the field of the active setting out of a packed per-setting vector
// assumes eight settings packed with setting 0 in the low bits
`timescale 1ns/1ps
module ccsb_bit_pick #(
    parameter int W = 1
) (
    // packed per-setting fields
    input wire logic [W*8-1:0] fieldVec,
    input wire logic [2:0] index,
    // selected field
    output logic [W-1:0] field
);
    // plain mux, no state
    assign field = fieldVec[W*int'(index) +: W];
endmodule // ccsb_bit_pick

/* rtl/ccsb_config_bank.sv */
// config bank of the clock synthesizer with its two-wire serial slave
// assumes pins synchronous to sys_clk and serial bit rate far below 10 MHz
`timescale 1ns/1ps
module ccsb_config_bank #(
    parameter logic VARIANT_BIT = 1'b0,          // arbitrary value
    parameter logic [2:0] REVISION_FIELD = 3'h0, // arbitrary value
    parameter logic [3:0] VENDOR_FIELD = 4'hA,   // arbitrary value
    parameter logic [4:0] SLAVE_ADDR_HI = 5'h16  // arbitrary value
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // select pins; mid is also serial data, high also serial clock
    input wire logic selectPinLow,
    input wire logic selectPinMidIn,
    output logic selectPinMidOut,
    output logic selectPinMidOe,
    input wire logic selectPinHigh,
    // controls for the synthesizer loop and outputs
    output logic [ccsb_pkg::IDX_W-1:0] activeIndex,
    output logic synthLoopEnable,
    output logic devicePowerDown,
    output logic firstOutputFromLoop,
    output logic firstOutputEnable,
    output logic firstOutputDriveLow,
    output logic firstOutputHighZ,
    output logic frequencyChoice,
    output logic [ccsb_pkg::SPREAD_W-1:0] spreadChoice,
    output logic secondThirdOutputState,
    output logic [1:0] inputSourceSelect,
    // nonvolatile status
    output logic nonvolatileLock,
    output logic serialPinsActive,
    output logic nvSaveBusy
);
    import ccsb_pkg::*;

    logic [7:0] cfgMem [0:CFG_DEPTH-1]; // working registers
    logic [7:0] nvMem [0:CFG_DEPTH-1];  // nonvolatile copy
    logic [4:0] saveCnt;                // save cycles left
    logic sclPrev, sdaPrev;             // last pin samples
    ccsb_ser_state_e serState;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;
    logic [6:0] ptrReg;                 // byte pointer
    logic isRead;
    logic ackSeen;                      // master acked read byte
    logic driveLow;                     // open-drain pull on data pin
    logic wrStrobe;                     // one-cycle commit pulse
    logic [4:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] rdCur, rdNext;
    logic [7:0] genByte, outByte, nvGen, nvOut, identByte;
    logic serialOn, sclNow, sdaNow, sclRise, sclFall, startSeen, stopSeen;
    logic saveGo;
    logic [2:0] idxC;
    logic firstStateBit, freqBit, secondThirdBit;
    logic [SPREAD_W-1:0] spreadBits;
    logic [1:0] defC;
    logic downC;

    // byte view seen by a serial read
    function automatic logic [7:0] readByte(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;                              // unmapped reads zero
        if (a[6:5] != 2'h0) v = 8'h00;
        else if (a[4:0] == OFF_IDENT)
            v = identByte;
        else if (a[4:0] == OFF_GENERAL)
            v = {1'b0, saveCnt != 5'h00, cfgMem[OFF_GENERAL][5:0]};
        else v = cfgMem[a[4:0]];
        return v;
    endfunction

    // convenience views
    assign genByte = cfgMem[OFF_GENERAL];
    assign outByte = cfgMem[OFF_OUTSRC];
    assign nvGen = nvMem[OFF_GENERAL];
    assign nvOut = nvMem[OFF_OUTSRC];
    // id fields are parameters, so no write path can reach them
    assign identByte = {VARIANT_BIT, REVISION_FIELD,
                        VENDOR_FIELD};
    assign nvSaveBusy = saveCnt != 5'h00;
    assign selectPinMidOut = 1'b0;       // open drain: only pulls low
    assign selectPinMidOe = driveLow;

    // serial pins exist only until select use is stored
    assign serialOn = !nvOut[OUT_PINFN];
    assign sclNow = selectPinHigh;
    assign sdaNow = selectPinMidIn;
    assign sclRise = !sclPrev && sclNow;
    assign sclFall = sclPrev && !sclNow;
    assign startSeen = sclPrev && sclNow && sdaPrev && !sdaNow;
    assign stopSeen = sclPrev && sclNow && !sdaPrev && sdaNow;

    // read data for current and next pointer
    always_comb begin
        rdCur = readByte(ptrReg);
        rdNext = readByte(ptrReg + 7'h01);
    end

    // pin history for edge and start/stop detection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclNow;
            sdaPrev <= sdaNow;
        end
    end

    // serial slave: byte write, byte read, auto-incremented sequences
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serState <= SER_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            ptrReg <= 7'h00;
            isRead <= 1'b0;
            ackSeen <= 1'b0;
            driveLow <= 1'b0;
            wrStrobe <= 1'b0;
            wrAddr <= 5'h00;
            wrData <= 8'h00;
        end else begin
            wrStrobe <= 1'b0;
            if (!serialOn) begin
                // pins belong to the selector now
                serState <= SER_IDLE;
                driveLow <= 1'b0;
            end else if (startSeen) begin
                serState <= SER_ADDR;
                bitCnt <= 4'h0;
                driveLow <= 1'b0;
            end else if (stopSeen) begin
                serState <= SER_IDLE;
                driveLow <= 1'b0;
            end else begin
                case (serState)
                    SER_ADDR, SER_CMD, SER_WDATA: begin
                        if (sclRise && bitCnt != BITS_PER_BYTE) begin
                            shiftReg <= {shiftReg[6:0], sdaNow};
                            bitCnt <= bitCnt + 4'h1;
                        end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
                            bitCnt <= 4'h0;
                            if (serState == SER_ADDR) begin
                                // low address bits come from the bank
                                if (shiftReg[7:1] == {SLAVE_ADDR_HI,
                                    genByte[GEN_ADR_HI:GEN_ADR_LO]}) begin
                                    isRead <= shiftReg[0];
                                    serState <= SER_ADDR_ACK;
                                    driveLow <= 1'b1;
                                end else begin
                                    serState <= SER_IDLE;
                                end
                            end else if (serState == SER_CMD) begin
                                ptrReg <= shiftReg[6:0];
                                serState <= SER_CMD_ACK;
                                driveLow <= 1'b1;
                            end else if (nvSaveBusy) begin
                                // no writes while a save runs: nack
                                serState <= SER_IDLE;
                            end else begin
                                wrStrobe <= ptrReg[6:5] == 2'h0;
                                wrAddr <= ptrReg[4:0];
                                wrData <= shiftReg;
                                serState <= SER_WDATA_ACK;
                                driveLow <= 1'b1;
                            end
                        end
                    end
                    SER_ADDR_ACK: begin
                        if (sclFall) begin
                            bitCnt <= 4'h0;
                            if (isRead) begin
                                shiftReg <= rdCur;
                                driveLow <= !rdCur[7];
                                serState <= SER_RDATA;
                            end else begin
                                driveLow <= 1'b0;
                                serState <= SER_CMD;
                            end
                        end
                    end
                    SER_CMD_ACK, SER_WDATA_ACK: begin
                        if (sclFall) begin
                            driveLow <= 1'b0;
                            if (serState == SER_WDATA_ACK)
                                ptrReg <= ptrReg + 7'h01;
                            serState <= SER_WDATA;
                        end
                    end
                    SER_RDATA: begin
                        if (sclFall) begin
                            if (bitCnt == 4'h7) begin
                                bitCnt <= 4'h0;
                                driveLow <= 1'b0;
                                serState <= SER_RDATA_ACK;
                            end else begin
                                shiftReg <= {shiftReg[6:0], 1'b0};
                                driveLow <= !shiftReg[6];
                                bitCnt <= bitCnt + 4'h1;
                            end
                        end
                    end
                    SER_RDATA_ACK: begin
                        if (sclRise) begin
                            ackSeen <= !sdaNow;
                        end else if (sclFall) begin
                            if (ackSeen) begin
                                ptrReg <= ptrReg + 7'h01;
                                shiftReg <= rdNext;
                                driveLow <= !rdNext[7];
                                serState <= SER_RDATA;
                            end else begin
                                serState <= SER_IDLE;    // wait for stop
                            end
                        end
                    end
                    default: serState <= SER_IDLE;
                endcase
            end
        end
    end

    // working registers; writes already refused while a save runs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < CFG_DEPTH; i++)
                cfgMem[i] <= ccsb_reset_byte(i);
        end else if (wrStrobe && !nvSaveBusy) begin
            case (wrAddr)
                OFF_IDENT: ;
                OFF_GENERAL: begin
                    cfgMem[OFF_GENERAL][GEN_RSVD] <= 1'b0;
                    cfgMem[OFF_GENERAL][GEN_BUSY] <= 1'b0;
                    cfgMem[OFF_GENERAL][GEN_LOCK] <=
                        wrData[GEN_LOCK];
                    cfgMem[OFF_GENERAL][GEN_PDN] <= wrData[GEN_PDN];
                    cfgMem[OFF_GENERAL][GEN_ADR_HI:GEN_ADR_LO] <=
                        wrData[GEN_ADR_HI:GEN_ADR_LO];
                    // reserved source code leaves the source alone
                    if (wrData[GEN_SRC_HI:GEN_SRC_LO] != SRC_RESERVED)
                        cfgMem[OFF_GENERAL][GEN_SRC_HI:GEN_SRC_LO] <=
                            wrData[GEN_SRC_HI:GEN_SRC_LO];
                end
                // the go bit is a trigger, never stored
                OFF_SAVE: cfgMem[OFF_SAVE] <= {wrData[7:1], 1'b0};
                default: cfgMem[wrAddr] <= wrData;
            endcase
        end
    end

    // save starts only when unlocked in nonvolatile storage
    assign saveGo = wrStrobe && wrAddr == OFF_SAVE && wrData[SAVE_GO] &&
                    !nvGen[GEN_LOCK] && !nvSaveBusy;

    // nonvolatile copy and save timer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            saveCnt <= 5'h00;
            for (int i = 0; i < CFG_DEPTH; i++)
                nvMem[i] <= ccsb_reset_byte(i);
        end else if (saveGo) begin
            saveCnt <= NV_SAVE_COUNT;
        end else if (nvSaveBusy) begin
            saveCnt <= saveCnt - 5'h01;
            if (saveCnt == 5'h01) begin
                for (int i = 0; i < CFG_DEPTH; i++)
                    nvMem[i] <= cfgMem[i];
                nvMem[OFF_GENERAL][GEN_PDN] <= 1'b0;
            end
        end
    end

    // shared pins count only when stored as select inputs
    always_comb begin
        idxC = {!serialOn && selectPinHigh, !serialOn && selectPinMidIn,
                selectPinLow};
    end

    // per-setting bits chosen by the active index
    ccsb_bit_pick #(.W(1)) pickFirst (
        .fieldVec(cfgMem[OFF_FIRST_STATE]),
        .index(idxC),
        .field(firstStateBit)
    );
    ccsb_bit_pick #(.W(1)) pickFreq (
        .fieldVec(cfgMem[OFF_FREQ]),
        .index(idxC),
        .field(freqBit)
    );
    ccsb_bit_pick #(.W(1)) pickSecond (
        .fieldVec(cfgMem[OFF_SECOND_THIRD]),
        .index(idxC),
        .field(secondThirdBit)
    );
    ccsb_bit_pick #(.W(SPREAD_W)) pickSpread (
        .fieldVec({cfgMem[OFF_SPREAD_HI], cfgMem[OFF_SPREAD_MID],
                   cfgMem[OFF_SPREAD_LO]}),
        .index(idxC),
        .field(spreadBits)
    );

    // output state definition and power down decision
    always_comb begin
        defC = firstStateBit ? outByte[ST1_HI:ST1_LO] : outByte[ST0_HI:ST0_LO];
        downC = genByte[GEN_PDN] || defC == ST_POWER_DOWN;
    end

    // registered control outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            activeIndex <= 3'h0;
            synthLoopEnable <= 1'b0;
            devicePowerDown <= 1'b1;
            firstOutputFromLoop <= 1'b1;
            firstOutputEnable <= 1'b0;
            firstOutputDriveLow <= 1'b0;
            firstOutputHighZ <= 1'b1;
            frequencyChoice <= 1'b0;
            spreadChoice <= 3'h0;
            secondThirdOutputState <= 1'b0;
            inputSourceSelect <= 2'h0;
            nonvolatileLock <= 1'b0;
            serialPinsActive <= 1'b1;
        end else begin
            activeIndex <= idxC;
            synthLoopEnable <= !downC;
            devicePowerDown <= downC;
            firstOutputFromLoop <= outByte[OUT_SRC];
            firstOutputEnable <= !downC && defC == ST_ENABLED;
            firstOutputDriveLow <= !downC && defC == ST_DRIVE_LOW;
            firstOutputHighZ <= downC || defC == ST_HIGH_Z;
            frequencyChoice <= freqBit;
            spreadChoice <= spreadBits;
            secondThirdOutputState <= secondThirdBit;
            inputSourceSelect <= genByte[GEN_SRC_HI:GEN_SRC_LO];
            nonvolatileLock <= nvGen[GEN_LOCK];
            serialPinsActive <= serialOn;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_variant_fixed: assert property (
        serState == SER_ADDR_ACK && sclFall && isRead && ptrReg == 7'h00
        |=> shiftReg[7] == VARIANT_BIT)
        else $error("variant bit not returned");
    a_revision_fixed: assert property (
        serState == SER_ADDR_ACK && sclFall && isRead && ptrReg == 7'h00
        |=> shiftReg[6:4] == REVISION_FIELD)
        else $error("revision field not returned");
    a_vendor_fixed: assert property (
        serState == SER_ADDR_ACK && sclFall && isRead && ptrReg == 7'h00
        |=> shiftReg[3:0] == VENDOR_FIELD)
        else $error("vendor field not returned");
    a_source_reserved: assert property (
        wrStrobe && wrAddr == OFF_GENERAL && wrData[3:2] == SRC_RESERVED
        |=> genByte[3:2] == $past(genByte[3:2]))
        else $error("reserved input source stored");
    a_pdn_override: assert property (
        genByte[GEN_PDN] |=> devicePowerDown && !synthLoopEnable &&
        !firstOutputEnable && firstOutputHighZ)
        else $error("power down did not stop outputs");
    a_nv_no_pdn: assert property (!nvGen[GEN_PDN])
        else $error("power down stored in nonvolatile copy");
    a_lock_no_save: assert property (
        nvGen[GEN_LOCK] && !nvSaveBusy |=> !nvSaveBusy)
        else $error("save started while locked");
    a_drive_low_decode: assert property (
        !downC && defC == ST_DRIVE_LOW |=> firstOutputDriveLow &&
        !firstOutputEnable && !firstOutputHighZ)
        else $error("drive-low state decoded wrongly");
    a_serial_released: assert property (
        nvOut[OUT_PINFN] |=> !selectPinMidOe && serState == SER_IDLE)
        else $error("serial pins active after stored select use");
    a_addr_match: assert property (
        $rose(serState == SER_ADDR_ACK) |->
        $past(shiftReg[7:1]) == {SLAVE_ADDR_HI, $past(genByte[1:0])})
        else $error("acked a foreign address");
    a_first_source: assert property (
        ##1 firstOutputFromLoop == $past(outByte[OUT_SRC]))
        else $error("first output source lags setting");
    a_freq_pick: assert property (
        ##1 frequencyChoice == $past(cfgMem[OFF_FREQ][idxC]))
        else $error("frequency bit not from active setting");
    a_save_length: assert property (
        saveGo |=> saveCnt == NV_SAVE_COUNT)
        else $error("save timer not loaded");

    c_save_done: cover property (saveCnt == 5'h01);
    c_read_byte: cover property (serState == SER_RDATA_ACK && sclFall);
    c_write_byte: cover property (wrStrobe);
    c_power_down: cover property ($rose(devicePowerDown));
endmodule // ccsb_config_bank

/* dv/ccsb_host_model.sv */
// two-wire host model driving the shared select/serial pins
// assumes a pulled-up data line resolved in the bench
`timescale 1ns/1ps
module ccsb_host_model (
    // clock
    input wire logic sys_clk,
    // bus lines
    input wire logic sdaIn,
    output logic scl,
    output logic sdaLow
);
    localparam logic [6:0] ADR = 7'h59; // address after reset
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // 4 cycles a phase, above the 3 the slave needs
    task automatic wt();
        repeat (4) @(posedge sys_clk);
    endtask
    // start or repeated start
    task automatic start();
        sdaLow <= 1'b0;
        wt();
        scl <= 1'b1;
        wt();
        sdaLow <= 1'b1;
        wt();
        scl <= 1'b0;
        wt();
    endtask
    task automatic stop();
        sdaLow <= 1'b1;
        wt();
        scl <= 1'b1;
        wt();
        sdaLow <= 1'b0;
        wt();
    endtask
    // one bit; data line sampled late in the high phase
    task automatic bit1(input logic b, output logic r);
        sdaLow <= ~b;
        wt();
        scl <= 1'b1;
        wt();
        r = sdaIn;
        scl <= 1'b0;
        wt();
    endtask
    // msb first, ninth bit driven with last
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit1(d[i], q[i]);
        end
        bit1(last, a);
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        logic [7:0] q;
        if (off == 8'h01) d[7] = 1'b0; // reserved bit kept clear
        start();
        xfer({ADR, 1'b0}, 1'b1, q);
        xfer(off, 1'b1, q);
        xfer(d, 1'b1, q);
        stop();
    endtask
    // read ends with a nack so the slave releases the line
    task automatic rd(input logic [7:0] off, output logic [7:0] q);
        start();
        xfer({ADR, 1'b0}, 1'b1, q);
        xfer(off, 1'b1, q);
        start();
        xfer({ADR, 1'b1}, 1'b1, q);
        xfer(8'hFF, 1'b1, q);
        stop();
    endtask
endmodule // ccsb_host_model

/* dv/tb_top.sv */
// self-checking bench for the clock synth config bank
// assumes the host model as the only bus master
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic selLow = 1'b0;
    logic scl, sdaLow, oe, pdn, loopEn, fromLoop, en, dl, hz, fq, st;
    logic lock, serOn, busy;
    logic [2:0] idx, spr;
    logic [1:0] src;
    int nFail = 0;
    int nChecks = 0;
    int busyCnt = 0;
    wire sda = ~(sdaLow | oe); // open drain with pull-up
    ccsb_host_model host (.sys_clk(sys_clk), .sdaIn(sda), .scl(scl),
        .sdaLow(sdaLow));
    // id byte D6 from arbitrary parameter values
    ccsb_config_bank #(.VARIANT_BIT(1'b1), .REVISION_FIELD(3'h5),
        .VENDOR_FIELD(4'h6)) dut (.sys_clk(sys_clk), .rst(rst),
        .selectPinLow(selLow), .selectPinMidIn(sda), .selectPinMidOut(),
        .selectPinMidOe(oe), .selectPinHigh(scl), .activeIndex(idx),
        .synthLoopEnable(loopEn), .devicePowerDown(pdn),
        .firstOutputFromLoop(fromLoop), .firstOutputEnable(en),
        .firstOutputDriveLow(dl), .firstOutputHighZ(hz),
        .frequencyChoice(fq), .spreadChoice(spr),
        .secondThirdOutputState(st), .inputSourceSelect(src),
        .nonvolatileLock(lock), .serialPinsActive(serOn),
        .nvSaveBusy(busy));
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (busy === 1'b1) busyCnt++;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (nFail == 0 && nChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic t_ident();
        logic [7:0] q;
        host.rd(8'h00, q);
        chk(q, 8'hD6);
        host.wr(8'h00, 8'h29);
        host.rd(8'h00, q);
        chk(q, 8'hD6);
        host.rd(8'h01, q);
        chk(q, 8'h01);
        host.rd(8'h02, q);
        chk(q, 8'hB4);
        chk({5'h0, fromLoop, serOn, lock}, 8'h06);
    endtask
    // power down and input source code handling
    task automatic t_general();
        logic [7:0] q;
        host.wr(8'h01, 8'h11);
        chk(8'({pdn, loopEn}), 8'h02);
        host.wr(8'h01, 8'h0D);
        host.rd(8'h01, q);
        chk(q, 8'h01);
        chk(8'({pdn, loopEn}), 8'h01);
        host.wr(8'h01, 8'h09);
        chk(8'(src), 8'h02);
    endtask
    // per-setting bits follow the low select pin
    task automatic t_select();
        host.wr(8'h13, 8'h02);
        host.wr(8'h15, 8'h01);
        host.wr(8'h10, 8'h38);
        for (int b = 0; b < 2; b++) begin
            selLow <= b[0];
            host.wt();
            chk(8'(idx), 8'(b));
            chk(8'({fq, st, spr}), b ? 8'h17 : 8'h08);
            chk(8'({en, hz}), b ? 8'h02 : 8'h01);
        end
        selLow <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            host.wr(8'h02, {4'hD, c[1:0], 2'h0});
            chk(8'({pdn, dl, en}), 8'({c == 0, c == 2, c == 3}));
        end
    endtask
    // save lock and pin function, then pins act as selects
    task automatic t_save();
        host.wr(8'h01, 8'h31);
        host.wr(8'h02, 8'h74);
        host.wr(8'h06, 8'h01);
        chk(8'(busyCnt), 8'h10);
        chk(8'({lock, serOn, pdn, fromLoop}), 8'h0A);
        host.sdaLow <= 1'b1;
        selLow <= 1'b1;
        host.wt();
        chk(8'(idx), 8'h05);
        host.scl <= 1'b0;
        host.sdaLow <= 1'b0;
        host.wt();
        chk(8'(idx), 8'h03);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_ident();
        t_general();
        t_select();
        t_save();
        report_and_stop();
    end
    // run needs about 7k cycles
    initial begin
        #6_000_000;
        nFail++;
        report_and_stop();
    end
endmodule // tb_top
